// ---- afe_test_eq_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Voice tone select feeds sine to voice DAC
// - Audio tone select feeds sine to audio DAC
// - Mute bit silences sine output
// - Redirect moves audio interrupt onto voice line
// - Audio interrupt every reload-plus-one pairs
// - 45-tap sum divided by 32768
// - Signed 16-bit coefficients, tap zero newest
// - Two-bit transcoder test mode selects four modes
// - Test transfer waits for interface reset
// - Voice start resets path, 8 kHz interrupts
module afe_test_eq_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [15:0] pwdata,
    output logic [15:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic voice_clock_gate_bit,
    input wire logic audio_clock_gate_bit,
    input wire logic test_interface_reset_signal_n,
    input wire logic [15:0] voice_sample,
    output logic [15:0] voice_dac_data,
    input wire logic [15:0] audio_in_data,
    input wire logic audio_in_valid,
    output logic audio_in_ready,
    output logic [15:0] audio_dac_data,
    output logic audio_dac_valid,
    input wire logic audio_dac_ready,
    output logic voice_irq,
    output logic audio_irq,
    output logic [1:0] transcoder_test_mode,
    output logic test_transfer_en
);
    typedef enum logic [3:0] {
        EQ_IDLE = 4'h1,
        EQ_MAC = 4'h2,
        EQ_OUT = 4'h4,
        EQ_SPARE = 4'h8
    } eq_state_t;

    function automatic logic [5:0] wrap_sub(input logic [5:0] a, input logic [5:0] b);
        wrap_sub = (a >= b) ? 6'(a - b) : 6'(a + 6'(afe_ctrl_pkg::TAPS) - b);
    endfunction

    function automatic logic [15:0] sat16(input logic signed [37:0] v);
        logic signed [37:0] s;
        s = v >>> afe_ctrl_pkg::EQ_SHIFT;
        if (s > 38'sh7FFF) sat16 = 16'h7FFF;
        else if (s < -38'sh8000) sat16 = 16'h8000;
        else sat16 = s[15:0];
    endfunction

    function automatic logic signed [15:0] sine_at(input logic [7:0] ph);
        logic [3:0] i;
        logic signed [15:0] q;
        i = ph[5] ? ~ph[5:2] : ph[5:2];
        case (i)
            4'h0: q = 16'h0C8C; 4'h1: q = 16'h2528; 4'h2: q = 16'h3C57; 4'h3: q = 16'h5134;
            4'h4: q = 16'h62F2; 4'h5: q = 16'h70E3; 4'h6: q = 16'h7A7D; 4'h7: q = 16'h7F62;
            default: q = 16'h7FFF;
        endcase
        sine_at = ph[6] ? -q : q;
    endfunction

    // ************************************************
    // Registers
    // ************************************************
    logic voice_start_r, audio_start_r, voice_tone_r, audio_tone_r, tone_mute_r, redirect_r, rst_seen_r;
    logic [4:0] tone_amplitude_r;
    logic [7:0] tone_frequency_r;
    logic [2:0] period_reload_r;
    logic [1:0] mode_r;
    logic wr_en, rd_en, addr_ok, coef_hit, mode_wr;
    logic [5:0] coef_idx;

    assign coef_hit = paddr >= afe_ctrl_pkg::OFF_COEF_FIRST && paddr <= afe_ctrl_pkg::OFF_COEF_LAST
                      && paddr[1:0] == 2'h0;
    assign coef_idx = 6'((paddr - afe_ctrl_pkg::OFF_COEF_FIRST) >> 2);
    assign addr_ok = coef_hit || paddr == afe_ctrl_pkg::OFF_VOICE_START || paddr == afe_ctrl_pkg::OFF_AUDIO_START
                     || paddr == afe_ctrl_pkg::OFF_SINE_TEST || paddr == afe_ctrl_pkg::OFF_IRQ_SET
                     || paddr == afe_ctrl_pkg::OFF_TEST_MODE;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign mode_wr = wr_en && paddr == afe_ctrl_pkg::OFF_TEST_MODE;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            voice_start_r <= 1'b0;
            audio_start_r <= 1'b0;
            voice_tone_r <= 1'b0;
            audio_tone_r <= 1'b0;
            tone_mute_r <= 1'b0;
            tone_amplitude_r <= afe_ctrl_pkg::AMP_RESET;
            tone_frequency_r <= afe_ctrl_pkg::FREQ_RESET;
            redirect_r <= 1'b0;
            period_reload_r <= afe_ctrl_pkg::PERIOD_RESET;
            mode_r <= afe_ctrl_pkg::MODE_NORMAL;
        end else if (wr_en) begin
            case (paddr)
                afe_ctrl_pkg::OFF_VOICE_START: voice_start_r <= pwdata[0];
                afe_ctrl_pkg::OFF_AUDIO_START: audio_start_r <= pwdata[0];
                afe_ctrl_pkg::OFF_SINE_TEST: begin
                    voice_tone_r <= pwdata[afe_ctrl_pkg::BIT_VOICE_TONE];
                    audio_tone_r <= pwdata[afe_ctrl_pkg::BIT_AUDIO_TONE];
                    tone_mute_r <= pwdata[afe_ctrl_pkg::BIT_TONE_MUTE];
                    tone_amplitude_r <= pwdata[afe_ctrl_pkg::AMP_LSB +: 5];
                    tone_frequency_r <= pwdata[afe_ctrl_pkg::FREQ_LSB +: 8];
                end
                afe_ctrl_pkg::OFF_IRQ_SET: begin
                    redirect_r <= pwdata[afe_ctrl_pkg::BIT_REDIRECT];
                    period_reload_r <= pwdata[2:0];
                end
                afe_ctrl_pkg::OFF_TEST_MODE: mode_r <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ************************************************
    // Register read path
    // ************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 16'h0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= !addr_ok;
            end
            if (rd_en) begin
                case (paddr)
                    afe_ctrl_pkg::OFF_VOICE_START: prdata <= {15'h0000, voice_start_r};
                    afe_ctrl_pkg::OFF_AUDIO_START: prdata <= {15'h0000, audio_start_r};
                    afe_ctrl_pkg::OFF_SINE_TEST: prdata <= {voice_tone_r, audio_tone_r, tone_mute_r,
                                                            tone_amplitude_r, tone_frequency_r};
                    afe_ctrl_pkg::OFF_IRQ_SET: prdata <= {redirect_r, 12'h000, period_reload_r};
                    afe_ctrl_pkg::OFF_TEST_MODE: prdata <= {13'h0000, rst_seen_r, mode_r};
                    default: prdata <= 16'h0000;
                endcase
            end
        end
    end

    // ************************************************
    // Test interface reset recognition
    // ************************************************
    logic dai_s1_r, dai_s2_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dai_s1_r <= 1'b1;
            dai_s2_r <= 1'b1;
        end else begin
            dai_s1_r <= test_interface_reset_signal_n;
            dai_s2_r <= dai_s1_r;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_seen_r <= 1'b0;
            transcoder_test_mode <= afe_ctrl_pkg::MODE_NORMAL;
            test_transfer_en <= 1'b0;
        end else begin
            if (!dai_s2_r && mode_r != afe_ctrl_pkg::MODE_NORMAL) rst_seen_r <= 1'b1;
            else if (mode_wr) rst_seen_r <= 1'b0;
            transcoder_test_mode <= mode_r;
            test_transfer_en <= rst_seen_r && mode_r != afe_ctrl_pkg::MODE_NORMAL;
        end
    end

    // ************************************************
    // Voice timing and tone generator
    // ************************************************
    logic voice_run, audio_run, voice_tick;
    logic [11:0] vcnt_r;
    logic [7:0] phase_r;
    logic [15:0] tone_word;
    assign voice_run = voice_start_r && !voice_clock_gate_bit;
    assign audio_run = audio_start_r && !audio_clock_gate_bit;
    assign voice_tick = voice_run && vcnt_r == 12'(afe_ctrl_pkg::VOICE_TICK_CYC - 1);
    assign tone_word = tone_mute_r ? 16'h0000 : 16'(sine_at(phase_r) >>> tone_amplitude_r);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vcnt_r <= 12'h000;
        end else if (!voice_run || voice_tick) begin
            vcnt_r <= 12'h000;
        end else begin
            vcnt_r <= 12'(vcnt_r + 12'h001);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= 8'h00;
        end else if (voice_tick) begin
            phase_r <= 8'(phase_r + tone_frequency_r);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            voice_dac_data <= 16'h0000;
        end else if (voice_tick) begin
            voice_dac_data <= voice_tone_r ? tone_word : voice_sample;
        end
    end

    // ************************************************
    // Two-entry input buffer
    // ************************************************
    logic [15:0] buf_r [0:1];
    logic [1:0] cnt_r;
    logic pop, push;
    assign push = audio_in_valid && audio_in_ready;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 2'h0;
            audio_in_ready <= 1'b0;
            buf_r[0] <= 16'h0000;
            buf_r[1] <= 16'h0000;
        end else begin
            cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
            audio_in_ready <= 2'(cnt_r + {1'b0, push} - {1'b0, pop}) < 2'h2;
            if (pop) buf_r[0] <= buf_r[1];
            if (push) buf_r[2'(cnt_r - {1'b0, pop}) == 2'h0 ? 0 : 1] <= audio_in_data;
        end
    end

    // ************************************************
    // Equalizer
    // ************************************************
    mem_if coef_bus ();
    mem_if hist_bus ();
    word_mem coef_mem (.clk(clk), .port(coef_bus.mem));
    word_mem hist_mem (.clk(clk), .port(hist_bus.mem));

    eq_state_t state_r;
    logic [5:0] k_r, newest_r, wp_r, fill_r;
    logic signed [37:0] acc_r;
    logic [2:0] pairs_r;
    logic out_done, audio_evt;
    logic signed [37:0] term;

    assign pop = state_r == EQ_IDLE && cnt_r != 2'h0 && audio_run;
    assign coef_bus.we = wr_en && coef_hit;
    assign coef_bus.waddr = coef_idx;
    assign coef_bus.wdata = pwdata;
    assign coef_bus.raddr = k_r;
    assign hist_bus.we = pop;
    assign hist_bus.waddr = wp_r;
    assign hist_bus.wdata = buf_r[0];
    assign hist_bus.raddr = wrap_sub(newest_r, k_r);
    assign out_done = state_r == EQ_OUT && audio_dac_ready;
    assign audio_evt = out_done && pairs_r == 3'h0;
    // Taps older than the samples taken since start count as zero
    assign term = (k_r <= fill_r) ? 38'($signed(coef_bus.rdata) * $signed(hist_bus.rdata)) : 38'sh0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= EQ_IDLE;
            k_r <= 6'h00;
            newest_r <= 6'h00;
            wp_r <= 6'h00;
            fill_r <= 6'h00;
            acc_r <= 38'sh0;
            audio_dac_data <= 16'h0000;
            audio_dac_valid <= 1'b0;
        end else if (!audio_run) begin
            state_r <= EQ_IDLE;
            wp_r <= 6'h00;
            fill_r <= 6'h00;
            audio_dac_valid <= 1'b0;
        end else begin
            case (state_r)
                EQ_IDLE: begin
                    if (pop) begin
                        newest_r <= wp_r;
                        if (fill_r != 6'(afe_ctrl_pkg::TAPS)) fill_r <= 6'(fill_r + 6'h01);
                        wp_r <= wp_r == 6'(afe_ctrl_pkg::TAPS - 1) ? 6'h00 : 6'(wp_r + 6'h01);
                        k_r <= 6'h00;
                        acc_r <= 38'sh0;
                        state_r <= EQ_MAC;
                    end
                end
                EQ_MAC: begin
                    if (k_r != 6'h00) begin
                        acc_r <= acc_r + term;
                    end
                    if (k_r == 6'(afe_ctrl_pkg::TAPS)) begin
                        state_r <= EQ_OUT;
                        audio_dac_valid <= 1'b1;
                        audio_dac_data <= audio_tone_r ? tone_word
                            : sat16(acc_r + term);
                    end
                    k_r <= 6'(k_r + 6'h01);
                end
                EQ_OUT: begin
                    if (audio_dac_ready) begin
                        audio_dac_valid <= 1'b0;
                        state_r <= EQ_IDLE;
                    end
                end
                default: state_r <= EQ_IDLE;
            endcase
        end
    end

    // ************************************************
    // Interrupts
    // ************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pairs_r <= afe_ctrl_pkg::PERIOD_RESET;
        end else if (!audio_run || audio_evt) begin
            pairs_r <= period_reload_r;
        end else if (out_done) begin
            pairs_r <= 3'(pairs_r - 3'h1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            voice_irq <= 1'b0;
            audio_irq <= 1'b0;
        end else begin
            voice_irq <= redirect_r ? audio_evt : voice_tick;
            audio_irq <= redirect_r ? 1'b0 : audio_evt;
        end
    end
endmodule
`default_nettype wire

// ---- afe_ctrl_pkg.sv ----
`default_nettype none
package afe_ctrl_pkg;
    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [7:0] OFF_VOICE_START = 8'h00;
    localparam logic [7:0] OFF_AUDIO_START = 8'h20;
    localparam logic [7:0] OFF_SINE_TEST = 8'h30;
    localparam logic [7:0] OFF_IRQ_SET = 8'h34;
    localparam logic [7:0] OFF_TEST_MODE = 8'h38;
    localparam logic [7:0] OFF_COEF_FIRST = 8'h40;
    localparam logic [7:0] OFF_COEF_LAST = 8'hF0;
    // ************************************************
    // Field positions and reset values
    // ************************************************
    localparam int BIT_VOICE_TONE = 15;
    localparam int BIT_AUDIO_TONE = 14;
    localparam int BIT_TONE_MUTE = 13;
    localparam int AMP_LSB = 8;
    localparam int FREQ_LSB = 0;
    localparam int BIT_REDIRECT = 15;
    localparam int BIT_RST_SEEN = 2;
    localparam logic [4:0] AMP_RESET = 5'h07;
    localparam logic [7:0] FREQ_RESET = 8'h01;
    localparam logic [2:0] PERIOD_RESET = 3'h5;
    // ************************************************
    // Equalizer and timing
    // ************************************************
    localparam int TAPS = 45;
    localparam int EQ_SHIFT = 15;
    localparam int CLK_HZ = 25000000;
    localparam int VOICE_RATE_HZ = 8000;
    localparam int VOICE_TICK_CYC = CLK_HZ / VOICE_RATE_HZ;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
endpackage
`default_nettype wire

// ---- mem_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mem_if;
    logic we;
    logic [5:0] waddr;
    logic [15:0] wdata;
    logic [5:0] raddr;
    logic [15:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ---- word_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module word_mem (
    input wire logic clk,
    mem_if.mem port
);
    logic [15:0] store [0:afe_ctrl_pkg::TAPS-1];

    // ************************************************
    // Write port and registered read port
    // ************************************************
    always_ff @(posedge clk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge clk) begin
        port.rdata <= store[port.raddr];
    end
endmodule
`default_nettype wire

// ---- afe_test_eq_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module afe_test_eq_ctrl_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [15:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic test_interface_reset_signal_n,
    input wire logic [15:0] audio_dac_data,
    input wire logic audio_dac_valid,
    input wire logic audio_dac_ready,
    input wire logic voice_irq,
    input wire logic audio_irq,
    input wire logic [1:0] transcoder_test_mode,
    input wire logic test_transfer_en
);
    logic [3:0] low_age_r;
    logic mode_wr;
    assign mode_wr = psel && penable && pwrite && paddr == 8'h38;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_age_r <= 4'hF;
        end else if (!test_interface_reset_signal_n) begin
            low_age_r <= 4'h0;
        end else if (low_age_r != 4'hF) begin
            low_age_r <= low_age_r + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ready;
        $past(nrst) |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low after reset");
    property p_unmapped;
        psel && penable && paddr == 8'h3C |-> pslverr && prdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mode_write;
        !$stable(transcoder_test_mode) |-> $past(mode_wr) || $past(mode_wr, 2);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("test mode changed without write");
    property p_xfer_mode;
        $rose(test_transfer_en) |-> transcoder_test_mode != 2'h0;
    endproperty
    a_xfer_mode: assert property (p_xfer_mode) else $error("transfer enabled in normal mode");
    property p_xfer_age;
        $rose(test_transfer_en) |-> low_age_r < 4'h8;
    endproperty
    a_xfer_age: assert property (p_xfer_age) else $error("transfer enabled without reset signaling");
    property p_dac_hold;
        audio_dac_valid && !audio_dac_ready |=> audio_dac_valid && $stable(audio_dac_data);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("output word dropped while stalled");
    property p_airq_cause;
        audio_irq |-> $past(audio_dac_valid && audio_dac_ready);
    endproperty
    a_airq_cause: assert property (p_airq_cause) else $error("audio interrupt without pair");
    property p_airq_pulse;
        audio_irq |=> !audio_irq;
    endproperty
    a_airq_pulse: assert property (p_airq_pulse) else $error("audio interrupt longer than a cycle");
    property p_virq_gap;
        voice_irq |=> !voice_irq [*8];
    endproperty
    a_virq_gap: assert property (p_virq_gap) else $error("voice interrupts too close");
endmodule
bind afe_test_eq_ctrl afe_test_eq_ctrl_properties i_props (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .test_interface_reset_signal_n, .audio_dac_data, .audio_dac_valid,
    .audio_dac_ready, .voice_irq, .audio_irq, .transcoder_test_mode, .test_transfer_en);
`default_nettype wire

// ---- test_afe_test_eq_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_afe_test_eq_ctrl;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [15:0] pwdata = 16'h0000;
    logic voice_clock_gate_bit = 1'b1;
    logic audio_clock_gate_bit = 1'b1;
    logic test_interface_reset_signal_n = 1'b1;
    logic [15:0] voice_sample = 16'h5A5A;
    logic [15:0] audio_in_data = 16'h0000;
    logic audio_in_valid = 1'b0;
    logic audio_dac_ready = 1'b0;
    logic [15:0] prdata, voice_dac_data, audio_dac_data, rd;
    logic pready, pslverr, audio_in_ready, audio_dac_valid, voice_irq, audio_irq, test_transfer_en, err;
    logic [1:0] transcoder_test_mode;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int n_airq = 0;
    int n_virq = 0;
    int a0, v0;
    afe_test_eq_ctrl i_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .voice_clock_gate_bit, .audio_clock_gate_bit, .test_interface_reset_signal_n,
        .voice_sample, .voice_dac_data, .audio_in_data, .audio_in_valid, .audio_in_ready, .audio_dac_data,
        .audio_dac_valid, .audio_dac_ready, .voice_irq, .audio_irq, .transcoder_test_mode, .test_transfer_en);
    // ************************************************
    // Clock, watchdog and helpers
    // ************************************************
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (audio_irq === 1'b1) n_airq++;
        if (voice_irq === 1'b1) n_virq++;
        if (cyc == 80000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        psel = 1'b1;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(negedge clk);
        penable = 1'b1;
        @(posedge clk);
        rd = prdata;
        err = pslverr;
        @(negedge clk);
        psel = 1'b0;
        penable = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input logic exp_err);
        apb(1'b0, a, 16'h0000);
        chk(rd, exp);
        chkb(err, exp_err);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic push(input logic [15:0] d);
        @(negedge clk);
        audio_in_valid = 1'b1;
        audio_in_data = d;
        while (audio_in_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        audio_in_valid = 1'b0;
    endtask
    task automatic pull(input logic [15:0] exp);
        while (audio_dac_valid !== 1'b1) @(negedge clk);
        wait_cyc(3);
        chk(audio_dac_data, exp);
        audio_dac_ready = 1'b1;
        @(negedge clk);
        audio_dac_ready = 1'b0;
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic s_regs();
        rdchk(8'h30, 16'h0701, 1'b0);
        rdchk(8'h34, 16'h0005, 1'b0);
        rdchk(8'h3C, 16'h0000, 1'b1);
        rdchk(8'h40, 16'h0000, 1'b0);
    endtask
    task automatic s_eq();
        for (int k = 0; k < 45; k++) begin
            apb(1'b1, 8'(8'h40 + 4 * k), k == 0 ? 16'h4000 : k == 1 ? 16'hC000 : 16'h0000);
        end
        audio_clock_gate_bit = 1'b0;
        apb(1'b1, 8'h20, 16'h0001);
        for (int k = 0; k < 45; k++) begin
            push(16'h0000);
            pull(16'h0000);
        end
        apb(1'b1, 8'h20, 16'h0000);
        push(16'h2000);
        push(16'h1000);
        wait_cyc(2);
        chkb(audio_in_ready, 1'b0);
        apb(1'b1, 8'h20, 16'h0001);
        pull(16'h1000);
        pull(16'hF800);
    endtask
    task automatic s_irq(input logic [15:0] set, input logic [15:0] ea, input logic [15:0] ev);
        apb(1'b1, 8'h20, 16'h0000);
        apb(1'b1, 8'h34, set);
        rdchk(8'h34, set, 1'b0);
        apb(1'b1, 8'h20, 16'h0001);
        a0 = n_airq;
        v0 = n_virq;
        for (int i = 0; i < 4; i++) begin
            push(i == 0 ? 16'h2000 : 16'h0000);
            pull(i == 0 ? 16'h1000 : i == 1 ? 16'hF000 : 16'h0000);
        end
        wait_cyc(3);
        chk(16'(n_airq - a0), ea);
        chk(16'(n_virq - v0), ev);
    endtask
    task automatic s_tone();
        apb(1'b1, 8'h34, 16'h0001);
        apb(1'b1, 8'h30, 16'h6701);
        push(16'h1234);
        pull(16'h0000);
        apb(1'b1, 8'h20, 16'h0000);
        audio_clock_gate_bit = 1'b1;
        apb(1'b1, 8'h30, 16'hA701);
        voice_clock_gate_bit = 1'b0;
        apb(1'b1, 8'h00, 16'h0001);
        wait_cyc(3200);
        chk(voice_dac_data, 16'h0000);
        apb(1'b1, 8'h30, 16'h0701);
        wait_cyc(6400);
        chk(voice_dac_data, 16'h5A5A);
        v0 = n_virq;
        wait_cyc(12500);
        chk(16'(n_virq - v0), 16'h0004);
        apb(1'b1, 8'h00, 16'h0000);
        voice_clock_gate_bit = 1'b1;
        wait_cyc(100);
        v0 = n_virq;
        wait_cyc(6400);
        chk(16'(n_virq - v0), 16'h0000);
        apb(1'b1, 8'h30, 16'h0701);
        voice_clock_gate_bit = 1'b0;
        wait_cyc(100);
        v0 = n_virq;
        wait_cyc(6400);
        chk(16'(n_virq - v0), 16'h0000);
        apb(1'b1, 8'h00, 16'h0001);
        v0 = n_virq;
        wait_cyc(6400);
        chk(16'(n_virq - v0), 16'h0002);
    endtask
    task automatic s_mode(input logic [1:0] m);
        apb(1'b1, 8'h38, {14'h0000, m});
        wait_cyc(3);
        chk({14'h0000, transcoder_test_mode}, {14'h0000, m});
        chkb(test_transfer_en, 1'b0);
        test_interface_reset_signal_n = 1'b0;
        wait_cyc(4);
        test_interface_reset_signal_n = 1'b1;
        wait_cyc(8);
        chkb(test_transfer_en, m != 2'h0);
        rdchk(8'h38, {13'h0000, m != 2'h0, m}, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        s_regs();
        s_eq();
        s_irq(16'h0001, 16'h0002, 16'h0000);
        s_irq(16'h8001, 16'h0000, 16'h0002);
        s_tone();
        for (int i = 1; i < 4; i++) s_mode(2'(i));
        s_mode(2'h0);
        end_sim();
    end
endmodule
`default_nettype wire
